// >>> cfgld_flash_model.sv
// serial flash stand-in for active loads: one nibble per config_clock period
// assumes config_clock_i and flash_sel_n_i come straight from the sequencer
`timescale 1ns/100ps
module cfgld_flash_model (
   // clock
   input  wire logic       mclk_i,
   // flash pins
   input  wire logic       flash_sel_n_i,
   input  wire logic       config_clock_i,
   output logic [3:0]      flash_data_o
);
   // ==========================================
   // data source, one process owns the nibble
   logic [3:0] nibble_reg = 4'h5;
   assign flash_data_o = nibble_reg;
   // deselected lines flip every cycle so a stale nibble never looks valid
   always @(posedge mclk_i) begin
      if (flash_sel_n_i) begin
         nibble_reg <= ~nibble_reg;
      end else if ($fell(config_clock_i)) begin
         nibble_reg <= nibble_reg + 4'h1; // new nibble after falling edge
      end
   end
endmodule // cfgld_flash_model

// >>> cfgld_pkg.sv
// constants and types shared by the configuration load sequencer
// assumes a single 250 MHz clock; all pins arrive synchronous to it
package cfgld_pkg;

   // ==========================================================================
   // clock and timing
   localparam int CLK_MHZ              = 250;
   localparam int CLK_PERIOD_NS        = 4;
   localparam int RESET_LOW_MIN_NS     = 320;
   localparam int RESET_LOW_CYC        = (RESET_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FIRST_DATA_DELAY_NS  = 1200;
   localparam int FIRST_DATA_DELAY_CYC =
      (FIRST_DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_USER_SMALL_US      = 12;
   localparam int T_USER_LARGE_US      = 25;
   localparam int T_USER_SMALL_CYC     = T_USER_SMALL_US * CLK_MHZ;
   localparam int T_USER_LARGE_CYC     = T_USER_LARGE_US * CLK_MHZ;
   localparam int DONE_RISE_CYC        = 1;

   // ==========================================================================
   // active mode config_clock dividers
   localparam int QUARTER_RATE_MHZ     = 20;
   localparam int EIGHTH_RATE_MHZ      = 10;
   localparam int QUARTER_RATE_DIV     = CLK_MHZ / QUARTER_RATE_MHZ;
   localparam int EIGHTH_RATE_DIV      = CLK_MHZ / EIGHTH_RATE_MHZ;
   localparam int CHAIN_FRAME_BITS     = 1344;

   // ==========================================================================
   // load image and jtag instruction register
   localparam int IMAGE_BITS           = 4096;
   localparam int IR_WIDTH             = 4;
   localparam logic [3:0] IR_RESET_VAL        = 4'hF;
   localparam logic [3:0] IR_LOAD_IMAGE       = 4'h3;
   localparam logic [3:0] IR_USER_ENTRY       = 4'h7;

   // ==========================================================================
   // enumerations
   typedef enum logic [1:0] {MODE_ACTIVE, MODE_PASSIVE, MODE_JTAG} cfgld_mode_type;

   typedef enum logic [2:0] {
      ST_START, ST_LOAD, ST_ARM, ST_WAIT, ST_USER, ST_HOLD
   } cfgld_state_type;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
      TAP_EX2_IR, TAP_UPD_IR
   } cfgld_tap_type;

endpackage

// >>> cfgld_seq.sv
// configuration load sequencer: reload trigger, active/passive/jtag load, user entry wait
// assumes all pins synchronous to mclk_i; bitstream contents are only counted and folded

`timescale 1ns/100ps

// Summary of operation
// - user mode follows done by at least 12 us, or 25 us on the large package option.
// - in jtag loads the wait starts once done is high and the user entry instruction updates.
// - active mode drives config_clock at the quarter rate (20 MHz) or eighth rate (10 MHz).
// - tdo changes only after a falling edge of tck.
// - in active and passive loads a chain master adds 1344 >> width_reg config_clock periods to the wait.
module cfgld_seq #(
   parameter int T_USER_SMALL_CYC = cfgld_pkg::T_USER_SMALL_CYC,
   parameter int T_USER_LARGE_CYC = cfgld_pkg::T_USER_LARGE_CYC,
   parameter int IMAGE_BITS       = cfgld_pkg::IMAGE_BITS
) (
   // clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      sys_rst_i,
   // straps and reload trigger
   input  wire logic                      creset_n_i,
   input  wire cfgld_pkg::cfgld_mode_type mode_i,
   input  wire logic                      rate_eighth_i,
   input  wire logic [2:0]                width_log2_i,
   input  wire logic                      chain_master_i,
   input  wire logic                      large_pkg_i,
   // active mode flash
   input  wire logic [3:0]                flash_data_i,
   output logic                           flash_sel_n_o,
   output logic                           config_clock_o,
   // passive mode host
   input  wire logic                      host_cclk_i,
   input  wire logic [31:0]               host_data_i,
   // jtag
   input  wire logic                      tck_i,
   input  wire logic                      tms_i,
   input  wire logic                      tdi_i,
   output logic                           tdo_o,
   // status
   output logic                           config_done_o,
   output logic                           user_mode_o,
   output logic                           iface_rst_o,
   output logic                           load_busy_o,
   output logic [31:0]                    image_check_o
);

   // =========================================================================
   // decoding helpers
   function automatic logic [5:0] lane_bits(input logic [2:0] w);
      lane_bits = (w > 3'd5) ? 6'd32 : 6'(1 << w);
   endfunction

   function automatic logic [31:0] lane_mask(input logic [2:0] w);
      lane_mask = (w >= 3'd5) ? 32'hFFFFFFFF : ((32'h00000001 << lane_bits(w)) - 32'h00000001);
   endfunction

   // =========================================================================
   // declarations
   cfgld_tap_if tap_bus ();

   cfgld_pkg::cfgld_state_type st_reg;
   cfgld_pkg::cfgld_mode_type  mode_reg;
   logic [2:0]                 width_reg;
   logic [7:0]                 div_reg;
   logic [7:0]                 low_cnt_reg;
   logic [7:0]                 div_cnt_reg;
   logic [15:0]                age_reg;
   logic [31:0]                bit_cnt_reg;
   logic [31:0]                wait_cnt_reg;
   logic [31:0]                wait_target_reg;
   logic                       host_prev_reg;
   logic                       take;
   logic [5:0]                 take_bits;
   logic [31:0]                take_data;
   logic                       reload;

   cfgld_tap u_tap (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .tck_i     (tck_i),
      .tms_i     (tms_i),
      .tdi_i     (tdi_i),
      .tap_bus   (tap_bus)
   );

   // =========================================================================
   // reload trigger: low pulse measured, load restarts on release
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         low_cnt_reg <= 8'h00;
      end else if (!creset_n_i) begin
         if (low_cnt_reg < 8'(cfgld_pkg::RESET_LOW_CYC)) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
         end
      end else begin
         low_cnt_reg <= 8'h00;
      end
   end

   // short glitches are ignored so a noisy line cannot wipe a running design
   assign reload = creset_n_i && (low_cnt_reg >= 8'(cfgld_pkg::RESET_LOW_CYC));

   // =========================================================================
   // data acceptance per mode
   always_comb begin
      take      = 1'b0;
      take_bits = 6'd1;
      take_data = 32'h00000000;
      case (mode_reg)
         cfgld_pkg::MODE_ACTIVE: begin
            take      = (div_cnt_reg == div_reg - 8'h01);
            take_bits = lane_bits((width_reg > 3'd2) ? 3'd2 : width_reg);
            take_data = {28'h0000000, flash_data_i} & lane_mask(width_reg);
         end
         cfgld_pkg::MODE_PASSIVE: begin
            // early edges are ignored; the host keeps first_data_delay
            take      = host_cclk_i && !host_prev_reg
                        && (age_reg >= 16'(cfgld_pkg::FIRST_DATA_DELAY_CYC));
            take_bits = lane_bits(width_reg);
            take_data = host_data_i & lane_mask(width_reg);
         end
         cfgld_pkg::MODE_JTAG: begin
            take      = tap_bus.shift_valid;
            take_data = {31'h00000000, tap_bus.shift_bit};
         end
         default: begin
            take = 1'b0;
         end
      endcase
      take = take && (st_reg == cfgld_pkg::ST_LOAD);
   end

   // =========================================================================
   // main sequencing state machine
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         st_reg          <= cfgld_pkg::ST_START;
         mode_reg        <= cfgld_pkg::MODE_ACTIVE;
         width_reg       <= 3'd0;
         div_reg         <= 8'(cfgld_pkg::QUARTER_RATE_DIV);
         bit_cnt_reg     <= 32'h00000000;
         wait_cnt_reg    <= 32'h00000000;
         wait_target_reg <= 32'h00000000;
         config_done_o   <= 1'b0;
         user_mode_o     <= 1'b0;
         image_check_o   <= 32'h00000000;
      end else if (reload || !creset_n_i) begin
         st_reg        <= reload ? cfgld_pkg::ST_START : st_reg;
         config_done_o <= reload ? 1'b0 : config_done_o;
         user_mode_o   <= reload ? 1'b0 : user_mode_o;
      end else begin
         case (st_reg)
            cfgld_pkg::ST_START: begin
               // straps caught once per load
               mode_reg      <= mode_i;
               width_reg     <= width_log2_i;
               div_reg       <= rate_eighth_i ? 8'(cfgld_pkg::EIGHTH_RATE_DIV)
                                              : 8'(cfgld_pkg::QUARTER_RATE_DIV);
               bit_cnt_reg   <= 32'h00000000;
               image_check_o <= 32'h00000000;
               config_done_o <= 1'b0;
               st_reg        <= cfgld_pkg::ST_LOAD;
            end
            cfgld_pkg::ST_LOAD: begin
               if (take) begin
                  bit_cnt_reg   <= bit_cnt_reg + 32'(take_bits);
                  image_check_o <= image_check_o ^ take_data;
               end
               if (bit_cnt_reg >= 32'(IMAGE_BITS)) begin
                  config_done_o <= 1'b1;
                  wait_target_reg <= 32'(large_pkg_i ? T_USER_LARGE_CYC : T_USER_SMALL_CYC)
                     + 32'(cfgld_pkg::DONE_RISE_CYC)
                     + ((chain_master_i && mode_reg != cfgld_pkg::MODE_JTAG)
                        ? (32'(cfgld_pkg::CHAIN_FRAME_BITS) >> width_reg) * 32'(div_reg)
                        : 32'h00000000);
                  wait_cnt_reg  <= 32'h00000000;
                  st_reg        <= (mode_reg == cfgld_pkg::MODE_JTAG) ? cfgld_pkg::ST_ARM
                                                                      : cfgld_pkg::ST_WAIT;
               end
            end
            cfgld_pkg::ST_ARM: begin
               if (tap_bus.update_ir && tap_bus.ir_is_user) begin
                  st_reg <= cfgld_pkg::ST_WAIT;
               end
            end
            cfgld_pkg::ST_WAIT: begin
               wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
               if (wait_cnt_reg + 32'h00000001 >= wait_target_reg) begin
                  user_mode_o <= 1'b1;
                  st_reg      <= cfgld_pkg::ST_USER;
               end
            end
            cfgld_pkg::ST_USER: begin
               user_mode_o <= 1'b1;
            end
            default: begin
               st_reg <= cfgld_pkg::ST_START;
            end
         endcase
      end
   end

   // =========================================================================
   // config_clock divider, runs only during an active load
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         div_cnt_reg    <= 8'h00;
         config_clock_o <= 1'b0;
         flash_sel_n_o  <= 1'b1;
      end else if (st_reg == cfgld_pkg::ST_LOAD && mode_reg == cfgld_pkg::MODE_ACTIVE) begin
         // odd ratios give a slightly longer low phase, inside the band
         div_cnt_reg    <= (div_cnt_reg >= div_reg - 8'h01) ? 8'h00 : div_cnt_reg + 8'h01;
         config_clock_o <= (div_cnt_reg >= div_reg - 8'h01) || (div_cnt_reg < (div_reg >> 1) - 8'h01);
         flash_sel_n_o  <= 1'b0;
      end else begin
         div_cnt_reg    <= 8'h00;
         config_clock_o <= 1'b0;
         flash_sel_n_o  <= 1'b1;
      end
   end

   // =========================================================================
   // load age for first data gating, host edge history
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         age_reg       <= 16'h0000;
         host_prev_reg <= 1'b0;
      end else begin
         host_prev_reg <= host_cclk_i;
         if (st_reg != cfgld_pkg::ST_LOAD) begin
            age_reg <= 16'h0000;
         end else if (age_reg != 16'hFFFF) begin
            age_reg <= age_reg + 16'h0001;
         end
      end
   end

   // =========================================================================
   // tdo only moves on the tck falling edge, giving the host a full half period
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tdo_o <= 1'b0;
      end else if (tap_bus.tck_fall) begin
         tdo_o <= tap_bus.tdo_bit;
      end
   end

   // =========================================================================
   // status outputs
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         iface_rst_o <= 1'b1;
         load_busy_o <= 1'b0;
      end else begin
         iface_rst_o <= !(st_reg == cfgld_pkg::ST_USER);
         load_busy_o <= (st_reg == cfgld_pkg::ST_LOAD);
      end
   end

   // =========================================================================
   // checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   logic [7:0] cclk_age_reg;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || (config_clock_o && !$past(config_clock_o))) begin
         cclk_age_reg <= 8'h01;
      end else if (cclk_age_reg != 8'hFF) begin
         cclk_age_reg <= cclk_age_reg + 8'h01;
      end
   end

   sequence s_armed_then_wait;
      (st_reg == cfgld_pkg::ST_ARM) ##1 (st_reg == cfgld_pkg::ST_WAIT);
   endsequence

   a_jtag_user_entry: assert property (s_armed_then_wait |->
      $past(tap_bus.update_ir) && config_done_o)
      else $error("jtag wait began without user entry instruction");

   a_user_min_wait: assert property ($rose(user_mode_o) |->
      ($past(wait_cnt_reg) + 32'h00000001 >= 32'(T_USER_SMALL_CYC)) && config_done_o)
      else $error("user mode before minimum wait");

   a_chain_master_wait: assert property ($rose(user_mode_o) |->
      $past(wait_cnt_reg) + 32'h00000001 == wait_target_reg)
      else $error("user entry wait length wrong");

   a_cclk_period: assert property ((config_clock_o && !$past(config_clock_o)
      && $past(config_clock_o, 2) == 1'b0 && !flash_sel_n_o && cclk_age_reg != 8'hFF
      && $past(load_busy_o, 40)) |-> cclk_age_reg == div_reg)
      else $error("config_clock period does not match divider");

   a_tdo_on_fall: assert property ($changed(tdo_o) |-> $past(tap_bus.tck_fall))
      else $error("tdo changed away from tck fall");

   a_done_low_load: assert property ($rose(config_done_o) |->
      $past(bit_cnt_reg) >= 32'(IMAGE_BITS))
      else $error("done rose before image complete");

   a_reload_clears: assert property ((st_reg == cfgld_pkg::ST_LOAD) |-> !config_done_o)
      else $error("done high during load");

endmodule // cfgld_seq

// >>> cfgld_tap.sv
// jtag tap controller tracker, oversampling tck on the system clock
// assumes tck well below a quarter of mclk_i
`timescale 1ns/100ps
module cfgld_tap (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic sys_rst_i,
   // jtag pins
   input  wire logic tck_i,
   input  wire logic tms_i,
   input  wire logic tdi_i,
   // sequencer side
   cfgld_tap_if.tap  tap_bus
);

   // =========================================================================
   // next tap state
   function automatic cfgld_pkg::cfgld_tap_type tap_next(input cfgld_pkg::cfgld_tap_type s,
                                                         input logic tms);
      case (s)
         cfgld_pkg::TAP_RESET:  tap_next = tms ? cfgld_pkg::TAP_RESET  : cfgld_pkg::TAP_IDLE;
         cfgld_pkg::TAP_IDLE:   tap_next = tms ? cfgld_pkg::TAP_SEL_DR : cfgld_pkg::TAP_IDLE;
         cfgld_pkg::TAP_SEL_DR: tap_next = tms ? cfgld_pkg::TAP_SEL_IR : cfgld_pkg::TAP_CAP_DR;
         cfgld_pkg::TAP_CAP_DR: tap_next = tms ? cfgld_pkg::TAP_EX1_DR : cfgld_pkg::TAP_SH_DR;
         cfgld_pkg::TAP_SH_DR:  tap_next = tms ? cfgld_pkg::TAP_EX1_DR : cfgld_pkg::TAP_SH_DR;
         cfgld_pkg::TAP_EX1_DR: tap_next = tms ? cfgld_pkg::TAP_UPD_DR : cfgld_pkg::TAP_PAU_DR;
         cfgld_pkg::TAP_PAU_DR: tap_next = tms ? cfgld_pkg::TAP_EX2_DR : cfgld_pkg::TAP_PAU_DR;
         cfgld_pkg::TAP_EX2_DR: tap_next = tms ? cfgld_pkg::TAP_UPD_DR : cfgld_pkg::TAP_SH_DR;
         cfgld_pkg::TAP_UPD_DR: tap_next = tms ? cfgld_pkg::TAP_SEL_DR : cfgld_pkg::TAP_IDLE;
         cfgld_pkg::TAP_SEL_IR: tap_next = tms ? cfgld_pkg::TAP_RESET  : cfgld_pkg::TAP_CAP_IR;
         cfgld_pkg::TAP_CAP_IR: tap_next = tms ? cfgld_pkg::TAP_EX1_IR : cfgld_pkg::TAP_SH_IR;
         cfgld_pkg::TAP_SH_IR:  tap_next = tms ? cfgld_pkg::TAP_EX1_IR : cfgld_pkg::TAP_SH_IR;
         cfgld_pkg::TAP_EX1_IR: tap_next = tms ? cfgld_pkg::TAP_UPD_IR : cfgld_pkg::TAP_PAU_IR;
         cfgld_pkg::TAP_PAU_IR: tap_next = tms ? cfgld_pkg::TAP_EX2_IR : cfgld_pkg::TAP_PAU_IR;
         cfgld_pkg::TAP_EX2_IR: tap_next = tms ? cfgld_pkg::TAP_UPD_IR : cfgld_pkg::TAP_SH_IR;
         cfgld_pkg::TAP_UPD_IR: tap_next = tms ? cfgld_pkg::TAP_SEL_DR : cfgld_pkg::TAP_IDLE;
         default:               tap_next = cfgld_pkg::TAP_RESET;
      endcase
   endfunction

   logic                                tck_prev_reg;
   cfgld_pkg::cfgld_tap_type            tap_reg;
   logic [cfgld_pkg::IR_WIDTH-1:0]      ir_shift_reg;
   logic [cfgld_pkg::IR_WIDTH-1:0]      ir_reg;
   logic                                bypass_reg;
   logic                                tck_rise;

   assign tck_rise = tck_i & ~tck_prev_reg;

   // tck edge history
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tck_prev_reg <= 1'b0;
      end else begin
         tck_prev_reg <= tck_i;
      end
   end

   // tap state, instruction and bypass registers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         tap_reg      <= cfgld_pkg::TAP_RESET;
         ir_shift_reg <= cfgld_pkg::IR_RESET_VAL;
         ir_reg       <= cfgld_pkg::IR_RESET_VAL;
         bypass_reg   <= 1'b0;
      end else if (tck_rise) begin
         tap_reg <= tap_next(tap_reg, tms_i);
         case (tap_reg)
            cfgld_pkg::TAP_RESET:  ir_reg       <= cfgld_pkg::IR_RESET_VAL;
            cfgld_pkg::TAP_CAP_IR: ir_shift_reg <= cfgld_pkg::IR_RESET_VAL;
            cfgld_pkg::TAP_SH_IR:  ir_shift_reg <= {tdi_i, ir_shift_reg[cfgld_pkg::IR_WIDTH-1:1]};
            cfgld_pkg::TAP_UPD_IR: ir_reg       <= ir_shift_reg;
            cfgld_pkg::TAP_SH_DR:  bypass_reg   <= tdi_i;
            default:               bypass_reg   <= bypass_reg;
         endcase
      end
   end

   // flags toward the sequencer
   assign tap_bus.update_ir   = tck_rise && (tap_reg == cfgld_pkg::TAP_UPD_IR);
   assign tap_bus.ir_is_user  = (ir_shift_reg == cfgld_pkg::IR_USER_ENTRY);
   assign tap_bus.shift_valid = tck_rise && (tap_reg == cfgld_pkg::TAP_SH_DR)
                                && (ir_reg == cfgld_pkg::IR_LOAD_IMAGE);
   assign tap_bus.shift_bit   = tdi_i;
   assign tap_bus.tdo_bit     = (tap_reg == cfgld_pkg::TAP_SH_IR) ? ir_shift_reg[0] : bypass_reg;
   assign tap_bus.tck_fall    = ~tck_i & tck_prev_reg;

endmodule // cfgld_tap

// >>> cfgld_tap_if.sv
// signals passed from the jtag tap tracker to the load sequencer
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface cfgld_tap_if;
   logic update_ir;    // pulse: tap left update-ir
   logic ir_is_user;   // level: instruction shift register holds user entry
   logic shift_valid;  // pulse: one image bit shifted in
   logic shift_bit;    // image bit
   logic tdo_bit;      // value due on tdo
   logic tck_fall;     // pulse: sampled tck fell

   modport tap (output update_ir, ir_is_user, shift_valid, shift_bit, tdo_bit, tck_fall);
   modport seq (input  update_ir, ir_is_user, shift_valid, shift_bit, tdo_bit, tck_fall);
endinterface

// >>> config_load_sequencing_tb.sv
// testbench for the load sequencer: active, reload, passive chain and jtag loads
// assumes short wait and image parameters so the run stays brief
`timescale 1ns/100ps
module config_load_sequencing_tb;
   // ==========================================
   // signals
   logic mclk_i = 1'b0, sys_rst_i = 1'b1, creset_n_i = 1'b1, rate_eighth_i = 1'b0;
   logic chain_master_i = 1'b0, large_pkg_i = 1'b0, host_cclk_i = 1'b0;
   logic tck_i = 1'b0, tms_i = 1'b0, tdi_i = 1'b0;
   logic [2:0] width_log2_i = 3'h2;
   logic [31:0] host_data_i = 32'h0;
   logic [31:0] image_check_o;
   logic [3:0] flash_data_i;
   cfgld_pkg::cfgld_mode_type mode_i = cfgld_pkg::MODE_ACTIVE;
   logic flash_sel_n_o, config_clock_o, tdo_o, config_done_o, user_mode_o;
   logic iface_rst_o, load_busy_o, h;
   int fail_count = 0, n_checks = 0, n;
   // ==========================================
   // design, flash and clock
   cfgld_seq #(.T_USER_SMALL_CYC(20), .T_USER_LARGE_CYC(40), .IMAGE_BITS(64)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .creset_n_i(creset_n_i), .mode_i(mode_i),
      .rate_eighth_i(rate_eighth_i), .width_log2_i(width_log2_i),
      .chain_master_i(chain_master_i), .large_pkg_i(large_pkg_i),
      .flash_data_i(flash_data_i), .flash_sel_n_o(flash_sel_n_o),
      .config_clock_o(config_clock_o), .host_cclk_i(host_cclk_i), .host_data_i(host_data_i),
      .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
      .config_done_o(config_done_o), .user_mode_o(user_mode_o), .iface_rst_o(iface_rst_o),
      .load_busy_o(load_busy_o), .image_check_o(image_check_o));
   cfgld_flash_model flash (.mclk_i(mclk_i), .flash_sel_n_i(flash_sel_n_o),
      .config_clock_i(config_clock_o), .flash_data_o(flash_data_i));
   initial forever #2 mclk_i = ~mclk_i;
   // ==========================================
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // count cycles until a level is seen high, bounded
   task automatic until_high(input int sel, output int cnt);
      cnt = 0;
      while ((sel == 0 ? config_done_o : sel == 1 ? user_mode_o :
              sel == 2 ? config_clock_o : !config_clock_o) !== 1'b1)
      begin
         @(posedge mclk_i);
         cnt++;
         if (cnt > 30000) begin
            fail_count++;
            report_and_stop();
         end
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge mclk_i);
   endtask
   task automatic reload(input int low);
      creset_n_i <= 1'b0;
      cycles(low);
      creset_n_i <= 1'b1;
      cycles(1);
   endtask
   // one passive clock period carrying one word
   task automatic host_word(input logic [31:0] d);
      host_data_i <= d;
      host_cclk_i <= 1'b1;
      cycles(4);
      host_cclk_i <= 1'b0;
      host_data_i <= ~d;
      cycles(4);
   endtask
   // the first divider period after load start is short, so measure a later one
   task automatic period_and_user(input int div, input int wait_cyc);
      int k;
      until_high(3, n);
      until_high(2, n);
      until_high(3, n);
      until_high(2, n);
      until_high(3, n);
      until_high(2, k);
      check("clock period", n + k, div);
      check("flash select", flash_sel_n_o, 1'b0);
      check("done early", config_done_o, 1'b0);
      until_high(0, n);
      until_high(1, n);
      check("user wait", (n >= wait_cyc - 1 && n <= wait_cyc + 2), 1'b1);
      check("iface held", iface_rst_o, 1'b1);
      cycles(2);
      check("iface free", iface_rst_o, 1'b0);
   endtask
   // one tck period of 10 cycles; hi is tdo just before tck falls
   task automatic tck_pulse(input logic ms, input logic di, output logic hi);
      tms_i <= ms;
      tdi_i <= di;
      cycles(2);
      tck_i <= 1'b1;
      cycles(4);
      hi = tdo_o;
      tck_i <= 1'b0;
      cycles(4);
   endtask
   // from idle through shift-ir to update-ir and back to idle
   task automatic ir_load(input logic [3:0] code);
      tck_pulse(1'b1, 1'b0, h);
      tck_pulse(1'b1, 1'b0, h);
      tck_pulse(1'b0, 1'b0, h);
      tck_pulse(1'b0, 1'b0, h);
      for (int b = 0; b < 4; b++) tck_pulse(b == 3, code[b], h);
      tck_pulse(1'b1, 1'b0, h);
      tck_pulse(1'b0, 1'b0, h);
   endtask
   // ==========================================
   // main sequence
   initial begin
      cycles(5);
      sys_rst_i <= 1'b0;
      period_and_user(12, 21);
      rate_eighth_i <= 1'b1;
      large_pkg_i <= 1'b1;
      reload(40);
      cycles(5);
      check("short reset", config_done_o, 1'b1);
      reload(80);
      cycles(4);
      check("reload done", config_done_o, 1'b0);
      period_and_user(25, 41);
      {rate_eighth_i, large_pkg_i, chain_master_i} <= 3'b001;
      mode_i <= cfgld_pkg::MODE_PASSIVE;
      width_log2_i <= 3'h5;
      reload(80);
      cycles(40);
      check("busy", load_busy_o, 1'b1);
      host_word(32'hA5A5_0F0F);
      host_word(32'h1234_5678);
      cycles(300);
      check("early words", config_done_o, 1'b0);
      host_word(32'hFFFF_0000);
      host_word(32'h0000_00FF);
      cycles(3);
      check("passive done", config_done_o, 1'b1);
      check("fold", image_check_o, 32'hFFFF_00FF);
      until_high(1, n);
      // done rose 9 edges before this wait began; 20 + 1 + (1344 / 32) * 12
      check("chain wait", (n + 8 >= 525 && n + 8 <= 528), 1'b1);
      // jtag load: image over shift-dr, then the user entry instruction
      mode_i <= cfgld_pkg::MODE_JTAG;
      reload(80);
      tck_pulse(1'b0, 1'b0, h);
      ir_load(cfgld_pkg::IR_LOAD_IMAGE);
      tck_pulse(1'b1, 1'b0, h);
      tck_pulse(1'b0, 1'b0, h);
      tck_pulse(1'b0, 1'b0, h);
      for (int i = 0; i < 64; i++) begin
         tck_pulse(i == 63, i[0], h);
         if (i > 0) check("tdo held", h, !i[0]);
         check("tdo after fall", tdo_o, i[0]);
      end
      tck_pulse(1'b1, 1'b0, h);
      tck_pulse(1'b0, 1'b0, h);
      cycles(40);
      check("jtag armed", {config_done_o, user_mode_o, load_busy_o}, 3'b100);
      check("jtag fold", image_check_o, 32'h00000000);
      ir_load(cfgld_pkg::IR_USER_ENTRY);
      until_high(1, n);
      // update seen 7 edges before the pulse ends, user_mode lags one edge
      check("jtag wait", n + 6, 21);
      report_and_stop();
   end
endmodule // config_load_sequencing_tb
